/* File: src/pis_pkg.sv */
// Shared constants and types for the power-on init sequencer.
// Assumes a single 100 MHz clock; the PARK_CYC, SETTLE_CYC and FILTER_CYC counts below are in cycles of it.
package pis_pkg;
	localparam int CLK_PERIOD_NS   = 10;
	localparam int PARK_TIME_NS    = 20000;
	localparam int PARK_CYC        = (PARK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_TIME_NS  = 1000;
	localparam int SETTLE_CYC      = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FILTER_TIME_NS  = 150;
	localparam int FILTER_CYC      = FILTER_TIME_NS / CLK_PERIOD_NS;
	localparam int SPI_DIV         = 4;
	localparam int HDR_BITS        = 32;
	localparam int CFG_BYTES       = 16;
	localparam int CFG_AW          = 4;
	localparam int LAST_BIT        = HDR_BITS + CFG_BYTES * 8 - 1;
	localparam logic [7:0]  FLASH_READ_CMD = 8'h03;
	localparam logic [23:0] FLASH_CFG_ADDR = 24'h000000;
	localparam int CFG_LIGHT_LSB   = 0;

	typedef enum logic [3:0] {
		S_RESET, S_PLL, S_FLASH, S_CFG, S_OFF, S_PWRUP, S_PROJ, S_PARK
	} pis_state_t;

	typedef struct packed {
		logic [1:0] light_sel;
		logic       light_oe;
		logic       flash_clk;
		logic       flash_out;
		logic       flash_cs_n;
		logic       flash_oe;
		logic       host_irq;
		logic       host_irq_oe;
	} pis_pins_t;

	typedef struct packed {
		pis_state_t        st;
		pis_pins_t         pins;
		logic [11:0]       cnt;
		logic [1:0]        div;
		logic [7:0]        bits;
		logic [31:0]       shift;
		logic [7:0]        rx;
		logic              mem_we;
		logic [CFG_AW-1:0] mem_addr;
		logic              pll_en;
		logic              power_en;
		logic              image_en;
		logic              park_req;
		logic              low_power;
		logic [3:0]        filt;
	} pis_regs_t;

	localparam pis_regs_t REGS_RST = '0;
endpackage

/* File: src/pis_cfg_mem.sv */
// Small store for configuration bytes loaded from the serial flash.
// Assumes one writer and one reader sharing the same address.
`timescale 1ns/1ps
module pis_cfg_mem (
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire logic                       we,
	input  wire logic [pis_pkg::CFG_AW-1:0] addr,
	input  wire logic [7:0]                 wdata,
	output logic      [7:0]                 rdata
);
	logic [7:0] mem [pis_pkg::CFG_BYTES];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		// Registered read keeps the output timing clean
		if (rst) begin
			rdata <= 8'h00;
		end else begin
			rdata <= mem[addr];
		end
	end
endmodule

/* File: src/pis_top.sv */
// Power-on init sequencer: reset hold, PLL lock, flash config load, on/off and mirror park.
// Assumes inputs synchronous to CLK; the pad ring resolves levels from the _OE outputs.
//
// Notes on behaviour
// RULE1: Power request high powers the projection path up and starts imaging.
// RULE2: Power request low powers down and enters the microwatt standby state.
// RULE3: Outside monitor holds system reset until supplies, park warning and clocks settle.
// RULE4: During system reset outputs sit inactive; shared pins are left as inputs.
// RULE5: During reset light select and flash pins are tri-stated.
// RULE6: After reset, wait for PLL lock, then read configuration from flash.
// RULE7: Losing core power tri-states all host-facing outputs.
// RULE8: Host interrupt is driven high right after reset release.
// RULE9: Host interrupt is driven low once initialization completes.
// RULE10: Host issues no bus commands until host interrupt has gone low.
// RULE11: Park warning arrives 40 us early, clock and reset kept meanwhile.
// RULE12: Falling power request parks the mirrors before power is removed.
`timescale 1ns/1ps
module pis_top (
	input  wire logic       CLK,
	input  wire logic       RST,
	input  wire logic       SYSTEM_RESET_N,
	input  wire logic       PROJECTOR_POWER_REQUEST,
	input  wire logic       FAST_SHUTDOWN_WARNING_N,
	input  wire logic       CORE_POWER_GOOD,
	input  wire logic       PLL_LOCKED,
	input  wire logic       FLASH_SERIAL_IN,
	output logic            PLL_ENABLE,
	output logic            HOST_IRQ,
	output logic            HOST_IRQ_OE,
	output logic            LIGHT_SOURCE_SELECT_0,
	output logic            LIGHT_SOURCE_SELECT_1,
	output logic            LIGHT_SOURCE_OE,
	output logic            FLASH_SERIAL_CLOCK,
	output logic            FLASH_SERIAL_OUT,
	output logic            FLASH_CHIP_SELECT_N,
	output logic            FLASH_OE,
	output logic            PROJECTION_POWER_EN,
	output logic            IMAGE_ENABLE,
	output logic            MIRROR_PARK,
	output logic            LOW_POWER_MODE
);
	pis_pkg::pis_regs_t r_q;
	pis_pkg::pis_regs_t r_d;
	logic [7:0]         mem_rdata;
	logic               park_now;
	logic               tick;
	logic [7:0]         data_bit;

	pis_cfg_mem i_pis_cfg_mem (
		.clk   (CLK),
		.rst   (RST),
		.we    (r_q.mem_we),
		.addr  (r_q.mem_addr),
		.wdata (r_q.rx),
		.rdata (mem_rdata)
	);

	// Glitch filter: short dips on the warning line are ignored
	assign park_now = (r_q.filt == 4'(pis_pkg::FILTER_CYC));
	assign tick     = (r_q.div == 2'(pis_pkg::SPI_DIV - 1));
	assign data_bit = r_q.bits - 8'(pis_pkg::HDR_BITS);

	always_comb begin
		r_d        = r_q;
		r_d.mem_we = 1'b0;
		if (FAST_SHUTDOWN_WARNING_N) begin
			r_d.filt = 4'h0;
		end else if (!park_now) begin
			r_d.filt = r_q.filt + 4'h1;
		end
		unique case (r_q.st)
			pis_pkg::S_RESET: begin
				r_d.st               = pis_pkg::S_PLL;
				r_d.pll_en           = 1'b1;
				r_d.pins.host_irq    = 1'b1; // [RULE8]
				r_d.pins.host_irq_oe = 1'b1; // [RULE8]
				// Deselect before the flash pins are ever enabled
				r_d.pins.flash_cs_n  = 1'b1; // [RULE6]
			end
			pis_pkg::S_PLL: begin
				// Flash is touched only once the PLL reports lock
				if (PLL_LOCKED) begin // [RULE6]
					r_d.st              = pis_pkg::S_FLASH;
					r_d.pins.flash_cs_n = 1'b0;
					r_d.pins.flash_oe   = 1'b1;
					r_d.pins.flash_clk  = 1'b0;
					r_d.shift           = {pis_pkg::FLASH_READ_CMD, pis_pkg::FLASH_CFG_ADDR};
					r_d.pins.flash_out  = pis_pkg::FLASH_READ_CMD[7];
					r_d.bits            = 8'h00;
					r_d.div             = 2'h0;
				end
			end
			pis_pkg::S_FLASH: begin
				r_d.div = tick ? 2'h0 : r_q.div + 2'h1;
				if (tick && !r_q.pins.flash_clk) begin
					r_d.pins.flash_clk = 1'b1;
					if (r_q.bits >= 8'(pis_pkg::HDR_BITS)) begin
						r_d.rx = {r_q.rx[6:0], FLASH_SERIAL_IN};
					end
				end else if (tick) begin
					r_d.pins.flash_clk = 1'b0;
					r_d.shift          = {r_q.shift[30:0], 1'b0};
					r_d.pins.flash_out = r_q.shift[30];
					r_d.bits           = r_q.bits + 8'h1;
					if (r_q.bits >= 8'(pis_pkg::HDR_BITS) && data_bit[2:0] == 3'h7) begin
						r_d.mem_we   = 1'b1;
						r_d.mem_addr = data_bit[2+pis_pkg::CFG_AW:3];
					end
					if (r_q.bits == 8'(pis_pkg::LAST_BIT)) begin
						r_d.st              = pis_pkg::S_CFG;
						r_d.pins.flash_cs_n = 1'b1;
						r_d.pins.flash_out  = 1'b0;
						r_d.cnt             = 12'h000;
					end
				end
			end
			pis_pkg::S_CFG: begin
				// Memory read is registered behind a registered address
				r_d.mem_addr = '0;
				r_d.cnt      = r_q.cnt + 12'h001;
				if (r_q.cnt == 12'h002) begin
					r_d.pins.light_sel = mem_rdata[pis_pkg::CFG_LIGHT_LSB +: 2];
					r_d.pins.light_oe  = 1'b1;
					r_d.pins.host_irq  = 1'b0; // [RULE9]
					r_d.st             = pis_pkg::S_OFF;
					r_d.low_power      = 1'b1;
				end
			end
			pis_pkg::S_OFF: begin
				// Start also needs the filtered warning (park_now) to be clear
				if (PROJECTOR_POWER_REQUEST && !park_now) begin // [RULE1]
					r_d.st        = pis_pkg::S_PWRUP;
					r_d.power_en  = 1'b1;
					r_d.low_power = 1'b0;
					r_d.cnt       = 12'h000;
				end
			end
			pis_pkg::S_PWRUP, pis_pkg::S_PROJ: begin
				r_d.cnt = r_q.cnt + 12'h001;
				if (!PROJECTOR_POWER_REQUEST || park_now) begin // [RULE12] [RULE11]
					r_d.st       = pis_pkg::S_PARK;
					r_d.image_en = 1'b0;
					r_d.park_req = 1'b1;
					r_d.cnt      = 12'h000;
				end else if (r_q.st == pis_pkg::S_PWRUP && r_q.cnt == 12'(pis_pkg::SETTLE_CYC - 1)) begin
					r_d.st       = pis_pkg::S_PROJ;
					r_d.image_en = 1'b1; // [RULE1]
				end
			end
			pis_pkg::S_PARK: begin
				r_d.cnt = r_q.cnt + 12'h001;
				// Park time fits well inside the 40 us warning window
				if (r_q.cnt == 12'(pis_pkg::PARK_CYC - 1)) begin
					r_d.st        = pis_pkg::S_OFF;
					r_d.park_req  = 1'b0;
					r_d.power_en  = 1'b0; // [RULE2]
					r_d.low_power = 1'b1; // [RULE2]
				end
			end
		endcase
		if (!SYSTEM_RESET_N) begin
			r_d      = pis_pkg::REGS_RST; // [RULE4] [RULE5]
			r_d.filt = r_q.filt;
		end
		if (!CORE_POWER_GOOD) begin
			r_d.pins.host_irq_oe = 1'b0; // [RULE7]
			r_d.pins.light_oe    = 1'b0; // [RULE7]
			r_d.pins.flash_oe    = 1'b0; // [RULE7]
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			r_q <= pis_pkg::REGS_RST;
		end else begin
			r_q <= r_d;
		end
	end

	assign PLL_ENABLE            = r_q.pll_en;
	assign HOST_IRQ              = r_q.pins.host_irq;
	assign HOST_IRQ_OE           = r_q.pins.host_irq_oe;
	assign LIGHT_SOURCE_SELECT_0 = r_q.pins.light_sel[0];
	assign LIGHT_SOURCE_SELECT_1 = r_q.pins.light_sel[1];
	assign LIGHT_SOURCE_OE       = r_q.pins.light_oe;
	assign FLASH_SERIAL_CLOCK    = r_q.pins.flash_clk;
	assign FLASH_SERIAL_OUT      = r_q.pins.flash_out;
	assign FLASH_CHIP_SELECT_N   = r_q.pins.flash_cs_n;
	assign FLASH_OE              = r_q.pins.flash_oe;
	assign PROJECTION_POWER_EN   = r_q.power_en;
	assign IMAGE_ENABLE          = r_q.image_en;
	assign MIRROR_PARK           = r_q.park_req;
	assign LOW_POWER_MODE        = r_q.low_power;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	property p_reset_quiet;
		!SYSTEM_RESET_N |=> !r_q.pins.light_oe && !r_q.pins.flash_oe && !r_q.pins.host_irq_oe && !r_q.power_en;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("Outputs active during reset"); // [RULE4] [RULE5]

	property p_irq_high;
		r_q.st == pis_pkg::S_RESET && SYSTEM_RESET_N && CORE_POWER_GOOD |=> HOST_IRQ && HOST_IRQ_OE;
	endproperty
	a_irq_high: assert property (p_irq_high) else $error("Interrupt not high after reset release"); // [RULE8]

	property p_pll_first;
		r_q.st == pis_pkg::S_PLL && !PLL_LOCKED && SYSTEM_RESET_N |=> r_q.pins.flash_cs_n;
	endproperty
	a_pll_first: assert property (p_pll_first) else $error("Flash selected before PLL lock"); // [RULE6]

	property p_irq_low;
		$fell(r_q.pins.host_irq) && $past(SYSTEM_RESET_N) |-> r_q.st == pis_pkg::S_OFF && r_q.low_power;
	endproperty
	a_irq_low: assert property (p_irq_low) else $error("Interrupt fell before init done"); // [RULE9]

	property p_power_up;
		r_q.st == pis_pkg::S_OFF && PROJECTOR_POWER_REQUEST && !park_now && SYSTEM_RESET_N
			|=> r_q.power_en ##1 !r_q.image_en;
	endproperty
	a_power_up: assert property (p_power_up) else $error("Power-up not started"); // [RULE1]

	property p_park_first;
		$fell(r_q.power_en) && $past(SYSTEM_RESET_N) |-> $past(r_q.park_req);
	endproperty
	a_park_first: assert property (p_park_first) else $error("Power removed without park"); // [RULE12]

	property p_park_hold;
		r_q.st == pis_pkg::S_PARK && r_q.cnt != 12'(pis_pkg::PARK_CYC - 1) && SYSTEM_RESET_N
			|=> r_q.park_req && r_q.power_en;
	endproperty
	a_park_hold: assert property (p_park_hold) else $error("Power removed during park"); // [RULE12]

	property p_standby;
		r_q.st == pis_pkg::S_PARK && r_q.cnt == 12'(pis_pkg::PARK_CYC - 1) && SYSTEM_RESET_N
			|=> r_q.low_power && !r_q.power_en && !r_q.park_req;
	endproperty
	a_standby: assert property (p_standby) else $error("Standby not entered after park"); // [RULE2]

	property p_core_loss;
		!CORE_POWER_GOOD |=> !HOST_IRQ_OE && !LIGHT_SOURCE_OE && !FLASH_OE;
	endproperty
	a_core_loss: assert property (p_core_loss) else $error("Outputs driven without core power"); // [RULE7]

	property p_fast_park;
		park_now && r_q.st == pis_pkg::S_PROJ && SYSTEM_RESET_N |=> r_q.park_req && !r_q.image_en;
	endproperty
	a_fast_park: assert property (p_fast_park) else $error("Warning did not start park"); // [RULE11]
endmodule

/* File: bench/pis_flash_model.sv */
// Serial flash stand-in: records the frame header and answers with a fixed config table.
// Assumes data sampled on rising serial clock and changed on falling, framed by chip select.
`timescale 1ns/1ps
module pis_flash_model #(
	parameter logic [7:0] CFG0 = 8'h02
) (
	input  wire logic        sclk,
	input  wire logic        cs_n,
	input  wire logic        mosi,
	output logic             miso,
	output logic [31:0]      hdr
);
	int n;

	initial begin
		n = 0;
		miso = 1'b0;
		hdr = '0;
	end

	always @(negedge cs_n) begin
		n = 0;
		hdr = '0;
	end

	always @(posedge sclk) begin
		if (!cs_n) begin
			if (n < 32)
				hdr = {hdr[30:0], mosi};
			n = n + 1;
		end
	end

	// Outside the data phase the line toggles so a stale bit never reads as valid
	always @(negedge sclk or negedge cs_n or posedge cs_n) begin
		logic [7:0] b;
		b = ((n - 32) / 8 == 0) ? CFG0 : 8'(((n - 32) / 8) ^ 8'h5a);
		if (cs_n || n < 32)
			miso = ~miso;
		else
			miso = b[7 - (n - 32) % 8];
	end
endmodule

/* File: bench/pis_top_tb.sv */
// Self-checking bench for the power-on init sequencer.
// Assumes the flash stand-in on the serial pins; the bench plays power monitor and host.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
	$display("unexpected %s: expected %h seen %h", nm, e, g); end end
module pis_top_tb;
	localparam logic [7:0] CFG0 = 8'h02;
	logic        CLK = 1'b0, RST = 1'b1, SYSTEM_RESET_N = 1'b0, PROJECTOR_POWER_REQUEST = 1'b0;
	logic        FAST_SHUTDOWN_WARNING_N = 1'b1, CORE_POWER_GOOD = 1'b1, PLL_LOCKED = 1'b0;
	logic        FLASH_SERIAL_IN, PLL_ENABLE, HOST_IRQ, HOST_IRQ_OE, LIGHT_SOURCE_SELECT_0;
	logic        LIGHT_SOURCE_SELECT_1, LIGHT_SOURCE_OE, FLASH_SERIAL_CLOCK, FLASH_SERIAL_OUT;
	logic        FLASH_CHIP_SELECT_N, FLASH_OE, PROJECTION_POWER_EN, IMAGE_ENABLE, MIRROR_PARK;
	logic        LOW_POWER_MODE;
	logic [31:0] hdr;
	int          failures = 0, n_checks = 0, cycles = 0;

	pis_top i_pis_top (.CLK(CLK), .RST(RST), .SYSTEM_RESET_N(SYSTEM_RESET_N),
		.PROJECTOR_POWER_REQUEST(PROJECTOR_POWER_REQUEST), .FAST_SHUTDOWN_WARNING_N(FAST_SHUTDOWN_WARNING_N),
		.CORE_POWER_GOOD(CORE_POWER_GOOD), .PLL_LOCKED(PLL_LOCKED), .FLASH_SERIAL_IN(FLASH_SERIAL_IN),
		.PLL_ENABLE(PLL_ENABLE), .HOST_IRQ(HOST_IRQ), .HOST_IRQ_OE(HOST_IRQ_OE),
		.LIGHT_SOURCE_SELECT_0(LIGHT_SOURCE_SELECT_0), .LIGHT_SOURCE_SELECT_1(LIGHT_SOURCE_SELECT_1),
		.LIGHT_SOURCE_OE(LIGHT_SOURCE_OE), .FLASH_SERIAL_CLOCK(FLASH_SERIAL_CLOCK),
		.FLASH_SERIAL_OUT(FLASH_SERIAL_OUT), .FLASH_CHIP_SELECT_N(FLASH_CHIP_SELECT_N), .FLASH_OE(FLASH_OE),
		.PROJECTION_POWER_EN(PROJECTION_POWER_EN), .IMAGE_ENABLE(IMAGE_ENABLE), .MIRROR_PARK(MIRROR_PARK),
		.LOW_POWER_MODE(LOW_POWER_MODE));

	pis_flash_model #(.CFG0(CFG0)) i_pis_flash_model (.sclk(FLASH_SERIAL_CLOCK), .cs_n(FLASH_CHIP_SELECT_N),
		.mosi(FLASH_SERIAL_OUT), .miso(FLASH_SERIAL_IN), .hdr(hdr));

	initial begin
		forever #5 CLK = ~CLK;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask

	task finish_test;
		if (failures == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Generous ceiling: two init loads plus two park cycles stay well under it
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			finish_test;
		end
	end

	task chk_idle;
		`CHK("oe", 3'b000, {HOST_IRQ_OE, LIGHT_SOURCE_OE, FLASH_OE})
		`CHK("outs", 4'h0, {PLL_ENABLE, PROJECTION_POWER_EN, IMAGE_ENABLE, MIRROR_PARK})
	endtask

	task t_init;
		int i;
		PROJECTOR_POWER_REQUEST = 1'b1;
		SYSTEM_RESET_N = 1'b1;
		tick(2);
		`CHK("irq", 3'b111, {HOST_IRQ, HOST_IRQ_OE, PLL_ENABLE})
		for (i = 0; i < 40; i++) begin
			tick(1);
			`CHK("cs_wait", 1'b0, FLASH_OE & ~FLASH_CHIP_SELECT_N)
		end
		PLL_LOCKED = 1'b1;
		for (i = 0; i < 3000 && HOST_IRQ !== 1'b0; i++)
			tick(1);
		`CHK("irq_done", 2'b01, {HOST_IRQ, HOST_IRQ_OE})
		`CHK("hdr", 32'h03000000, hdr)
		`CHK("light", {1'b1, CFG0[1:0]}, {LIGHT_SOURCE_OE, LIGHT_SOURCE_SELECT_1, LIGHT_SOURCE_SELECT_0})
		`CHK("early_req", 2'b01, {PROJECTION_POWER_EN, LOW_POWER_MODE})
		PROJECTOR_POWER_REQUEST = 1'b0;
		tick(3);
	endtask

	task t_onoff;
		PROJECTOR_POWER_REQUEST = 1'b1;
		tick(2);
		`CHK("pwr_up", 2'b10, {PROJECTION_POWER_EN, LOW_POWER_MODE})
		tick(98);
		`CHK("img_early", 1'b0, IMAGE_ENABLE)
		tick(1);
		`CHK("img_on", 1'b1, IMAGE_ENABLE)
		PROJECTOR_POWER_REQUEST = 1'b0;
		tick(2);
		`CHK("park", 3'b011, {IMAGE_ENABLE, MIRROR_PARK, PROJECTION_POWER_EN})
		tick(1998);
		`CHK("park_hold", 2'b11, {MIRROR_PARK, PROJECTION_POWER_EN})
		tick(1);
		`CHK("pwr_dn", 3'b001, {MIRROR_PARK, PROJECTION_POWER_EN, LOW_POWER_MODE})
	endtask

	task t_fast_park;
		int i;
		PROJECTOR_POWER_REQUEST = 1'b1;
		tick(105);
		FAST_SHUTDOWN_WARNING_N = 1'b0;
		for (i = 0; i < 20 && MIRROR_PARK !== 1'b1; i++)
			tick(1);
		`CHK("fpark", 3'b011, {IMAGE_ENABLE, MIRROR_PARK, PROJECTION_POWER_EN})
		for (i = 0; i < 2100 && MIRROR_PARK !== 1'b0; i++)
			tick(1);
		`CHK("fpark_dn", 2'b01, {PROJECTION_POWER_EN, LOW_POWER_MODE})
		tick(20);
		`CHK("warn_hold", 1'b0, PROJECTION_POWER_EN)
		FAST_SHUTDOWN_WARNING_N = 1'b1;
		PROJECTOR_POWER_REQUEST = 1'b0;
		tick(20);
	endtask

	task t_core_loss;
		CORE_POWER_GOOD = 1'b0;
		tick(2);
		`CHK("core_loss", 3'b000, {HOST_IRQ_OE, LIGHT_SOURCE_OE, FLASH_OE})
		CORE_POWER_GOOD = 1'b1;
		SYSTEM_RESET_N = 1'b0;
		PLL_LOCKED = 1'b0;
		tick(2);
		chk_idle();
	endtask

	initial begin
		tick(8);
		RST = 1'b0;
		tick(2);
		chk_idle();
		t_init();
		t_onoff();
		t_fast_park();
		t_core_loss();
		t_init();
		finish_test;
	end
endmodule
